// [inc/msi_pkg.sv]
// Package for the motion sensor interrupt control block.
// Assumes a single 125 MHz clock domain and an 8-bit internal register port.
`default_nettype none

package msi_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_CFG_OFS   = 8'h17;
  localparam logic [7:0] INIT_BYTE_OFS = 8'h1A;
  localparam logic [7:0] FREE_BYTE_OFS = 8'h1B;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_CFG_RST   = 8'h00;
  localparam logic [7:0] INIT_BYTE_RST = 8'h00;
  localparam logic [7:0] FREE_BYTE_RST = 8'h00;
  localparam int DRIVE_BIT    = 0;
  localparam int POLARITY_BIT = 1;
  localparam int WAKE_BIT     = 2;
  localparam int SAMPLE_BIT   = 3;
  localparam int EMPTY_BIT    = 4;
  localparam int FULL_BIT     = 5;
  localparam int LEVEL_BIT    = 6;
  localparam int STANDBY_BIT  = 7;
  localparam int QUEUE_DEPTH  = 32;

  // ----------------------------------------------------------------
  // Event carrier from the sensing core
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wake_to_continuous;   // Activity in watch mode, moved to continuous sampling
    logic new_sample;           // Sample written to output registers or queue
    logic standby_activity;     // Activity seen in standby-wake mode
  } msi_event_s;

endpackage : msi_pkg

`default_nettype wire

// [tb/motion_sensor_irq_control_test.sv]
// Self-checking bench for the interrupt control block and its bytes.
// Assumes the host model resolves the wire; queue and events come from here.
`timescale 1ns/100ps
`default_nettype none
module motion_sensor_irq_control_test;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic                clock_i = 1'b0;
  logic                reset_i = 1'b1;
  logic [7:0]          addr = 8'h00, wdata = 8'h00, rdata, cfg = 8'h00;
  logic                wr = 1'b0, mode = 1'b0, qen = 1'b0, clr = 1'b0;
  logic                pin_o, oe_n, pend, line;
  logic [5:0]          count = 6'h01;
  logic [4:0]          level = 5'h05;
  msi_pkg::msi_event_s ev = '0;
  int                  n_errors = 0, checked = 0, cycles = 0;
  always #4 clock_i = ~clock_i;
  msi_irq_ctrl u_msi_irq_ctrl (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .event_i(ev),
    .standby_wake_mode_i(mode), .queue_enable_i(qen), .queue_count_i(count),
    .queue_level_setting_i(level), .irq_clear_i(clr), .irq_out_pin_i(line),
    .irq_out_pin_o(pin_o), .irq_out_pin_oe_n_o(oe_n), .irq_pending_o(pend));
  msi_host_model u_msi_host_model (.pin_data_i(pin_o), .pin_oe_n_i(oe_n), .wire_level_o(line));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
    if (a == msi_pkg::IRQ_CFG_OFS) cfg = d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i) addr <= a;
    @(negedge clock_i) check(rdata, exp);
  endtask : rd_reg
  // Line level follows polarity; pending flag follows the request
  // Drive mode decides whether data or enable carries the level
  task automatic pin(input logic act);
    logic lvl;
    @(negedge clock_i) lvl = act ? cfg[1] : ~cfg[1];
    check({7'h00, line}, {7'h00, lvl});
    check({7'h00, pend}, {7'h00, act});
    check({6'h00, oe_n, pin_o}, cfg[0] ? {7'h00, lvl} : {6'h00, lvl, 1'b0});
  endtask : pin
  task automatic do_clear();
    @(posedge clock_i) clr <= 1'b1;
    @(posedge clock_i) clr <= 1'b0;
  endtask : do_clear
  task automatic ev_case(input logic [7:0] c, input logic [2:0] e, input logic m, input logic x);
    wr_reg(msi_pkg::IRQ_CFG_OFS, c);
    mode <= m;
    do_clear();
    @(posedge clock_i) ev <= e;
    @(posedge clock_i) ev <= '0;
    pin(x);
    do_clear();
    pin(1'b0);
  endtask : ev_case
  task automatic q_case(input logic [7:0] c, input logic en, input logic [5:0] f,
                        input logic [5:0] t, input logic x);
    wr_reg(msi_pkg::IRQ_CFG_OFS, c);
    @(posedge clock_i);
    qen   <= en;
    count <= f;
    do_clear();
    @(posedge clock_i) count <= t;
    @(posedge clock_i);
    pin(x);
  endtask : q_case
  task automatic t_reset();
    wr_reg(8'h1A, 8'h00);
    rd_reg(8'h17, 8'h00);
    rd_reg(8'h1A, 8'h00);
    rd_reg(8'h1B, 8'h00);
    pin(1'b0);
  endtask : t_reset
  // Event and clear in the same cycle: the event must win
  task automatic t_clear_race();
    wr_reg(msi_pkg::IRQ_CFG_OFS, 8'h08);
    @(posedge clock_i);
    ev  <= 3'b010;
    clr <= 1'b1;
    @(posedge clock_i);
    ev  <= '0;
    clr <= 1'b0;
    pin(1'b1);
    do_clear();
    pin(1'b0);
  endtask : t_clear_race
  task automatic t_regs();
    wr_reg(8'h1B, 8'h5A);
    rd_reg(8'h1B, 8'h5A);
    wr_reg(8'h17, 8'hC3);
    wr_reg(8'h1C, 8'h33);
    rd_reg(8'h1C, 8'h00);
    rd_reg(8'h17, 8'hC3);
    wr_reg(8'h17, 8'h00);
    rd_reg(8'h1B, 8'h5A);
  endtask : t_regs
  // Every drive and polarity combination, enabled and disabled
  task automatic t_sample();
    for (int m = 0; m < 4; m++) begin
      ev_case(8'h08 | 8'(m), 3'b010, 1'b0, 1'b1);
      ev_case(8'(m), 3'b010, 1'b0, 1'b0);
    end
  endtask : t_sample
  task automatic t_wake();
    ev_case(8'h04, 3'b100, 1'b0, 1'b1);
    ev_case(8'h00, 3'b100, 1'b0, 1'b0);
    ev_case(8'h80, 3'b001, 1'b1, 1'b1);
    ev_case(8'h80, 3'b001, 1'b0, 1'b0);
  endtask : t_wake
  task automatic t_queue();
    q_case(8'h10, 1'b1, 6'd1, 6'd0, 1'b1);
    q_case(8'h10, 1'b0, 6'd1, 6'd0, 1'b0);
    q_case(8'h00, 1'b1, 6'd1, 6'd0, 1'b0);
    q_case(8'h20, 1'b1, 6'd31, 6'd32, 1'b1);
    q_case(8'h20, 1'b1, 6'd30, 6'd31, 1'b0);
    q_case(8'h40, 1'b1, 6'd4, 6'd5, 1'b1);
    q_case(8'h40, 1'b1, 6'd6, 6'd7, 1'b0);
    q_case(8'h40, 1'b0, 6'd4, 6'd5, 1'b0);
  endtask : t_queue
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    t_reset();
    t_regs();
    t_clear_race();
    t_sample();
    t_wake();
    t_queue();
    report_and_stop();
  end
endmodule : motion_sensor_irq_control_test
`default_nettype wire

// [tb/msi_host_model.sv]
// Host side of the interrupt line: the pulled-up wire as the microcontroller sees it.
// Assumes the sensor pin data and its active-low output enable.
`timescale 1ns/100ps
`default_nettype none
module msi_host_model (
  input  wire logic pin_data_i,
  input  wire logic pin_oe_n_i,
  output logic      wire_level_o
);
  // External pull-up wins whenever the sensor releases the line
  assign wire_level_o = pin_oe_n_i ? 1'b1 : pin_data_i;
endmodule : msi_host_model
`default_nettype wire

// [verilog/msi_irq_ctrl.sv]
// Interrupt request logic with its configuration, init and free storage bytes.
// Assumes events arrive as one-cycle pulses synchronous to clock_i, and the
// register port is the device's internal 8-bit read/write port.
// Notes on behaviour
// - Config bit 0: 0 open-drain output, 1 push-pull output.
// - Config bit 1: 0 request active low, 1 active high.
// - Bit 2 enables interrupt on watch-mode activity moving to continuous sampling.
// - Bit 3 enables interrupt on every new sample written.
// - Bit 4 enables interrupt when queue sample count reaches zero.
// - Bit 5 enables interrupt when queue sample count reaches 32.
// - Bit 6 enables interrupt when queue reaches the programmed level.
// - Bit 7 enables activity interrupt only while in standby-wake mode.
// - Config register is read/write and resets to all zero.
// - Free storage byte holds any value, resets zero, affects nothing.
// - Queue interrupts stay inactive unless the queue enable is set.
`timescale 1ns/100ps
`default_nettype none

module msi_irq_ctrl #(
  parameter int COUNT_W = 6
) (
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic                reg_wr_i,
  input  wire logic [7:0]          reg_wdata_i,
  output logic      [7:0]          reg_rdata_o,
  input  wire msi_pkg::msi_event_s event_i,
  input  wire logic                standby_wake_mode_i,
  input  wire logic                queue_enable_i,
  input  wire logic [COUNT_W-1:0]  queue_count_i,
  input  wire logic [4:0]          queue_level_setting_i,
  input  wire logic                irq_clear_i,
  input  wire logic                irq_out_pin_i,
  output logic                     irq_out_pin_o,
  output logic                     irq_out_pin_oe_n_o,
  output logic                     irq_pending_o
);

  logic [7:0] irq_source_and_pin_config_q;
  logic [7:0] startup_init_byte_q;
  logic [7:0] free_storage_byte_q;
  logic [5:0] pend_q;
  logic [5:0] pend_d;
  logic       cnt_empty;
  logic       cnt_full;
  logic       cnt_level;
  logic       empty_q;
  logic       full_q;
  logic       level_q;
  logic       active;
  logic       line_level;
  logic       unused_pin;

  assign unused_pin = irq_out_pin_i;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Configuration byte, all sources off after reset
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      irq_source_and_pin_config_q <= msi_pkg::IRQ_CFG_RST;
    end else if (reg_wr_i && reg_addr_i == msi_pkg::IRQ_CFG_OFS) begin
      irq_source_and_pin_config_q <= reg_wdata_i;
    end
  end

  // Init byte is plain storage; the host is expected to clear it
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      startup_init_byte_q <= msi_pkg::INIT_BYTE_RST;
    end else if (reg_wr_i && reg_addr_i == msi_pkg::INIT_BYTE_OFS) begin
      startup_init_byte_q <= reg_wdata_i;
    end
  end

  // Free storage byte, feeds nothing else
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      free_storage_byte_q <= msi_pkg::FREE_BYTE_RST;
    end else if (reg_wr_i && reg_addr_i == msi_pkg::FREE_BYTE_OFS) begin
      free_storage_byte_q <= reg_wdata_i;
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    case (reg_addr_i)
      msi_pkg::IRQ_CFG_OFS:   reg_rdata_o = irq_source_and_pin_config_q;
      msi_pkg::INIT_BYTE_OFS: reg_rdata_o = startup_init_byte_q;
      msi_pkg::FREE_BYTE_OFS: reg_rdata_o = free_storage_byte_q;
      default:                reg_rdata_o = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Queue level events
  // ----------------------------------------------------------------
  // Count conditions; only the edge into each condition is an event,
  // so a queue sitting empty does not refire after a clear
  assign cnt_empty = queue_count_i == COUNT_W'(0);
  assign cnt_full  = queue_count_i == COUNT_W'(msi_pkg::QUEUE_DEPTH);
  assign cnt_level = queue_count_i >= COUNT_W'(queue_level_setting_i);

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      empty_q <= 1'b1;
      full_q  <= 1'b0;
      level_q <= 1'b0;
    end else begin
      empty_q <= cnt_empty;
      full_q  <= cnt_full;
      level_q <= cnt_level;
    end
  end

  // ----------------------------------------------------------------
  // Pending flags: set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    pend_d = irq_clear_i ? 6'h00 : pend_q;
    if (irq_source_and_pin_config_q[msi_pkg::WAKE_BIT] && event_i.wake_to_continuous) begin
      pend_d[0] = 1'b1;
    end
    if (irq_source_and_pin_config_q[msi_pkg::SAMPLE_BIT] && event_i.new_sample) begin
      pend_d[1] = 1'b1;
    end
    if (queue_enable_i && irq_source_and_pin_config_q[msi_pkg::EMPTY_BIT]
        && cnt_empty && !empty_q) begin
      pend_d[2] = 1'b1;
    end
    if (queue_enable_i && irq_source_and_pin_config_q[msi_pkg::FULL_BIT]
        && cnt_full && !full_q) begin
      pend_d[3] = 1'b1;
    end
    if (queue_enable_i && irq_source_and_pin_config_q[msi_pkg::LEVEL_BIT]
        && cnt_level && !level_q) begin
      pend_d[4] = 1'b1;
    end
    if (irq_source_and_pin_config_q[msi_pkg::STANDBY_BIT] && standby_wake_mode_i
        && event_i.standby_activity) begin
      pend_d[5] = 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pend_q <= 6'h00;
    end else begin
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  // Level the host should see on the wire, from the request and polarity
  assign active     = |pend_d;
  assign line_level = active ~^ irq_source_and_pin_config_q[msi_pkg::POLARITY_BIT];

  // Registered so the pin never glitches on combinational paths
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      irq_pending_o      <= 1'b0;
      irq_out_pin_o      <= 1'b0;
      irq_out_pin_oe_n_o <= 1'b1;
    end else begin
      irq_pending_o <= active;
      if (irq_source_and_pin_config_q[msi_pkg::DRIVE_BIT]) begin
        // Push-pull: the level is driven at all times
        irq_out_pin_o      <= line_level;
        irq_out_pin_oe_n_o <= 1'b0;
      end else begin
        // Open drain: pull low when line should be low, else release to the pull-up
        irq_out_pin_o      <= 1'b0;
        irq_out_pin_oe_n_o <= line_level;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_cfg_reset_zero: assert property (
    @(posedge clock_i) $fell(reset_i)
    |-> irq_source_and_pin_config_q == msi_pkg::IRQ_CFG_RST)
    else $error("config not zero after reset");
  a_cfg_write_store: assert property (
    @(posedge clock_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == msi_pkg::IRQ_CFG_OFS
    |=> irq_source_and_pin_config_q == $past(reg_wdata_i))
    else $error("config write lost");
  a_free_readback: assert property (
    @(posedge clock_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == msi_pkg::FREE_BYTE_OFS
    |=> reg_addr_i != msi_pkg::FREE_BYTE_OFS || reg_rdata_o == $past(reg_wdata_i))
    else $error("free byte readback wrong");
  // Request shows on the pending output one edge after the event
  a_sample_raises: assert property (
    @(posedge clock_i) disable iff (reset_i)
    event_i.new_sample && irq_source_and_pin_config_q[msi_pkg::SAMPLE_BIT]
    |=> irq_pending_o)
    else $error("sample event not raised");
  a_wake_masked: assert property (
    @(posedge clock_i) disable iff (reset_i)
    event_i.wake_to_continuous && !irq_source_and_pin_config_q[msi_pkg::WAKE_BIT]
    && !pend_q[0] |=> !pend_q[0])
    else $error("masked wake raised");
  // No queue flag may rise while the queue is off
  a_queue_gated: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !queue_enable_i |=> (pend_q[4:2] & ~$past(pend_q[4:2])) == 3'h0)
    else $error("queue gate broken");
  a_full_raises: assert property (
    @(posedge clock_i) disable iff (reset_i)
    queue_enable_i && irq_source_and_pin_config_q[msi_pkg::FULL_BIT]
    && queue_count_i == COUNT_W'(msi_pkg::QUEUE_DEPTH)
    && $past(queue_count_i) != COUNT_W'(msi_pkg::QUEUE_DEPTH) |=> pend_q[3])
    else $error("full event not raised");
  a_standby_only: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !standby_wake_mode_i && !pend_q[5] && !irq_clear_i |=> !pend_q[5])
    else $error("standby event outside mode");
  // An event in the clear cycle must survive the clear
  a_set_beats_clear: assert property (
    @(posedge clock_i) disable iff (reset_i)
    irq_clear_i && event_i.new_sample && irq_source_and_pin_config_q[msi_pkg::SAMPLE_BIT]
    |=> pend_q[1])
    else $error("event lost in clear cycle");
  a_clear_drops: assert property (
    @(posedge clock_i) disable iff (reset_i)
    irq_clear_i && !event_i.wake_to_continuous && !event_i.new_sample
    && !event_i.standby_activity && !queue_enable_i |=> !irq_pending_o)
    else $error("request not dropped by clear");
  // Pin follows the request and the config seen at the launching edge
  a_pushpull_level: assert property (
    @(posedge clock_i) disable iff (reset_i)
    irq_source_and_pin_config_q[msi_pkg::DRIVE_BIT] |=> !irq_out_pin_oe_n_o
    && irq_out_pin_o == (irq_pending_o ~^ $past(irq_source_and_pin_config_q[1])))
    else $error("push-pull level wrong");
  a_opendrain_drive: assert property (
    @(posedge clock_i) disable iff (reset_i)
    !irq_source_and_pin_config_q[msi_pkg::DRIVE_BIT] |=> !irq_out_pin_o
    && irq_out_pin_oe_n_o == (irq_pending_o ~^ $past(irq_source_and_pin_config_q[1])))
    else $error("open-drain drive wrong");

endmodule : msi_irq_ctrl

`default_nettype wire
